// >>> logic/ram_cfg_pkg.sv
// shared types and constants of the configurable dual-port ram
// assumes one clock domain and an apb master for the small control block
package ram_cfg_pkg;

  // ****************************************
  // configuration types
  // ****************************************
  typedef enum logic [1:0] {WRITE_FIRST_MODE, READ_FIRST_MODE, NO_CHANGE_MODE} write_mode_t;
  typedef enum logic [1:0] {CASCADE_NONE, CASCADE_FIRST, CASCADE_MIDDLE, CASCADE_LAST} cascade_t;
  typedef enum logic {PRIO_RESET, PRIO_GATE} priority_t;
  typedef enum logic {CLOCKS_INDEPENDENT, CLOCKS_COMMON} clock_relation_t;
  typedef enum logic {TRUE_TWO_PORT_USAGE, SIMPLE_TWO_PORT_USAGE} usage_t;
  typedef enum logic [1:0] {DOZE_AWAKE, DOZE_ASLEEP, DOZE_WAKING} doze_state_t;

  // ****************************************
  // array geometry and timing
  // ****************************************
  localparam int VEC_BITS = 256;
  localparam int CONTENT_VECS_SMALL = 64;
  localparam int CONTENT_VECS_LARGE = 128;
  localparam int PARITY_VECS_LARGE = 16;
  localparam int CONTENT_BITS_MAX = CONTENT_VECS_LARGE * VEC_BITS;
  localparam int PARITY_BITS_MAX = PARITY_VECS_LARGE * VEC_BITS;
  localparam int DATA_PINS = 72;
  localparam int ADDR_PINS = 15;
  localparam int PARITY_GROUP = 9;
  localparam int WIDEST_SIMPLE = 72;
  localparam logic [1:0] WAKE_CYCLES = 2'h2;

  // ****************************************
  // apb register map
  // ****************************************
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;
  localparam logic [APB_ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [APB_ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam int CTRL_DOZE_BIT = 0;
  localparam int STATUS_ASLEEP_BIT = 0;
  localparam int STATUS_READY_BIT = 1;
  localparam int STATUS_CASC_A_LSB = 2;
  localparam int STATUS_CASC_B_LSB = 4;
  localparam int STATUS_SKIP_LSB = 16;
  localparam int SKIP_W = 16;

  // legal port width, optionally with the wide simple two-port width
  function automatic bit width_ok(input int w, input bit allow72);
    return (w inside {0, 1, 2, 4, 9, 18, 36}) || (allow72 && w == WIDEST_SIMPLE);
  endfunction

endpackage

// >>> logic/port_output_stage.sv
// output latch and optional pipeline register of one ram port
// assumes the latch load and its data are decided by the parent array logic
`timescale 1ns/1ps
`default_nettype none
module port_output_stage #(
  parameter bit                                     OUT_REG     = 1'b1,
  parameter ram_cfg_pkg::priority_t                 PRIORITY    = ram_cfg_pkg::PRIO_RESET,
  parameter logic [ram_cfg_pkg::DATA_PINS-1:0]      RESET_VALUE = '0,
  parameter logic [ram_cfg_pkg::DATA_PINS-1:0]      INIT_VALUE  = '0
) (
  input  wire logic                                 clk,
  input  wire logic                                 reset_n,
  input  wire logic                                 loadLatch,
  input  wire logic [ram_cfg_pkg::DATA_PINS-1:0]    latchData,
  input  wire logic                                 regGate,
  input  wire logic                                 regReset,
  output logic      [ram_cfg_pkg::DATA_PINS-1:0]    dataOut
);
  import ram_cfg_pkg::*;

  typedef struct packed {
    logic [DATA_PINS-1:0] latch;
    logic [DATA_PINS-1:0] pipe;
  } stage_t;

  stage_t q_r;
  stage_t q_nxt;

  // ****************************************
  // next state of latch and register
  // ****************************************
  always_comb begin
    q_nxt = q_r;
    if (loadLatch) begin
      q_nxt.latch = latchData;
    end
    if (!OUT_REG && regReset) begin
      q_nxt.latch = RESET_VALUE;
    end
    if (OUT_REG) begin
      if (regReset && (PRIORITY == PRIO_RESET || regGate)) begin
        q_nxt.pipe = RESET_VALUE;
      end else if (regGate) begin
        q_nxt.pipe = q_r.latch;
      end
    end
  end

  // state register, both stages start at the initial value
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q_r <= '{latch: INIT_VALUE, pipe: INIT_VALUE};
    end else begin
      q_r <= q_nxt;
    end
  end

  // pipeline register adds one cycle of read latency
  assign dataOut = OUT_REG ? q_r.pipe : q_r.latch;

endmodule
`default_nettype wire

// >>> logic/dual_port_ram.sv
// configurable dual-port block ram with doze control over apb
// assumes both ports and the apb slave share clk; resets are synchronous
`timescale 1ns/1ps
`default_nettype none
module dual_port_ram #(
  parameter bit                                  LARGE_VARIANT = 1'b0,
  parameter ram_cfg_pkg::usage_t                 USAGE = ram_cfg_pkg::TRUE_TWO_PORT_USAGE,
  parameter int                                  READ_WIDTH_A = 0,
  parameter int                                  READ_WIDTH_B = 0,
  parameter int                                  WRITE_WIDTH_A = 0,
  parameter int                                  WRITE_WIDTH_B = 0,
  parameter ram_cfg_pkg::write_mode_t            WRITE_MODE_A = ram_cfg_pkg::WRITE_FIRST_MODE,
  parameter ram_cfg_pkg::write_mode_t            WRITE_MODE_B = ram_cfg_pkg::WRITE_FIRST_MODE,
  parameter bit                                  OUT_REG_A = 1'b1,
  parameter bit                                  OUT_REG_B = 1'b1,
  parameter ram_cfg_pkg::priority_t              PORT_A_RESET_VS_GATE_PRIORITY = ram_cfg_pkg::PRIO_RESET,
  parameter ram_cfg_pkg::priority_t              PORT_B_RESET_VS_GATE_PRIORITY = ram_cfg_pkg::PRIO_RESET,
  parameter logic [ram_cfg_pkg::DATA_PINS-1:0]   PORT_A_RESET_VALUE = '0,
  parameter logic [ram_cfg_pkg::DATA_PINS-1:0]   PORT_B_RESET_VALUE = '0,
  parameter logic [ram_cfg_pkg::DATA_PINS-1:0]   PORT_A_INIT_VALUE = '0,
  parameter logic [ram_cfg_pkg::DATA_PINS-1:0]   PORT_B_INIT_VALUE = '0,
  parameter ram_cfg_pkg::cascade_t               CASCADE_ORDER_A = ram_cfg_pkg::CASCADE_NONE,
  parameter ram_cfg_pkg::cascade_t               CASCADE_ORDER_B = ram_cfg_pkg::CASCADE_NONE,
  parameter ram_cfg_pkg::clock_relation_t        PORT_CLOCK_RELATION = ram_cfg_pkg::CLOCKS_INDEPENDENT,
  parameter bit                                  ADDRESS_HOLD_OPTION_A = 1'b0,
  parameter bit                                  ADDRESS_HOLD_OPTION_B = 1'b0,
  parameter bit                                  REPEAT_READ_SUPPRESS_A = 1'b0,
  parameter bit                                  REPEAT_READ_SUPPRESS_B = 1'b0,
  parameter bit                                  EARLIER_FAMILY = 1'b0,
  parameter bit                                  ASYNCHRONOUS_DOZE_SELECT = 1'b0,
  parameter logic [ram_cfg_pkg::CONTENT_BITS_MAX-1:0] CONTENT_INIT_VECTORS = '0,
  parameter logic [ram_cfg_pkg::PARITY_BITS_MAX-1:0]  PARITY_INIT_VECTORS = '0
) (
  input  wire logic                                 clk,
  input  wire logic                                 reset_n,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [ram_cfg_pkg::APB_ADDR_W-1:0]   paddr,
  input  wire logic [ram_cfg_pkg::APB_DATA_W-1:0]   pwdata,
  output logic      [ram_cfg_pkg::APB_DATA_W-1:0]   prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic                                 portAAccessOn,
  input  wire logic                                 portAWriteOn,
  input  wire logic                                 portAAddressCapture,
  input  wire logic [ram_cfg_pkg::ADDR_PINS-1:0]    portAAddr,
  input  wire logic [ram_cfg_pkg::DATA_PINS-1:0]    portAWrData,
  input  wire logic                                 portAOutputRegClockGate,
  input  wire logic                                 portAOutputRegReset,
  output logic      [ram_cfg_pkg::DATA_PINS-1:0]    portARdData,
  input  wire logic                                 portBAccessOn,
  input  wire logic                                 portBWriteOn,
  input  wire logic                                 portBAddressCapture,
  input  wire logic [ram_cfg_pkg::ADDR_PINS-1:0]    portBAddr,
  input  wire logic [ram_cfg_pkg::DATA_PINS-1:0]    portBWrData,
  input  wire logic                                 portBOutputRegClockGate,
  input  wire logic                                 portBOutputRegReset,
  output logic      [ram_cfg_pkg::DATA_PINS-1:0]    portBRdData
);
  import ram_cfg_pkg::*;

  // ****************************************
  // geometry
  // ****************************************
  localparam int WA = (READ_WIDTH_A > WRITE_WIDTH_A) ? READ_WIDTH_A : WRITE_WIDTH_A;
  localparam int WB = (READ_WIDTH_B > WRITE_WIDTH_B) ? READ_WIDTH_B : WRITE_WIDTH_B;
  localparam int WMAX = (WA > WB) ? WA : WB;
  localparam int W = (WMAX == 0) ? 1 : WMAX;
  localparam int PW = (W >= PARITY_GROUP) ? W / PARITY_GROUP : 0;
  localparam int PWX = (PW == 0) ? 1 : PW;
  localparam int DW = W - PW;
  localparam int VECS = LARGE_VARIANT ? CONTENT_VECS_LARGE : CONTENT_VECS_SMALL;
  localparam int DEPTH = VECS * VEC_BITS / DW;
  localparam int AW = $clog2(DEPTH);
  localparam bit ALLOW72 = LARGE_VARIANT && (USAGE == SIMPLE_TWO_PORT_USAGE);
  localparam logic [DATA_PINS-1:0] WMASK = DATA_PINS'({DATA_PINS{1'b1}} >> (DATA_PINS - W));
  localparam logic [1:0] PORT_USED = {WB != 0, WA != 0};
  localparam logic [1:0] HOLD = {ADDRESS_HOLD_OPTION_B, ADDRESS_HOLD_OPTION_A};
  localparam logic [1:0] SUPPRESS_ON = {REPEAT_READ_SUPPRESS_B, REPEAT_READ_SUPPRESS_A}
                                       & {2{PORT_CLOCK_RELATION == CLOCKS_COMMON}};
  localparam write_mode_t MODE [2] = '{WRITE_MODE_A, WRITE_MODE_B};

  // ****************************************
  // elaboration checks
  // ****************************************
  if (!width_ok(READ_WIDTH_A, ALLOW72) || !width_ok(READ_WIDTH_B, 1'b0)
      || !width_ok(WRITE_WIDTH_A, 1'b0) || !width_ok(WRITE_WIDTH_B, ALLOW72)) begin : g_bad_width
    $error("illegal port width");
  end
  if ((READ_WIDTH_A != 0 && READ_WIDTH_A != W) || (READ_WIDTH_B != 0 && READ_WIDTH_B != W)
      || (WRITE_WIDTH_A != 0 && WRITE_WIDTH_A != W)
      || (WRITE_WIDTH_B != 0 && WRITE_WIDTH_B != W)) begin : g_mixed_width
    $error("all used port widths must be equal");
  end
  if (USAGE == SIMPLE_TWO_PORT_USAGE && WRITE_MODE_A != WRITE_MODE_B) begin : g_bad_mode
    $error("simple usage needs equal write modes");
  end
  if ((REPEAT_READ_SUPPRESS_A || REPEAT_READ_SUPPRESS_B)
      && PORT_CLOCK_RELATION != CLOCKS_COMMON) begin : g_bad_suppress
    $error("repeat read suppression needs common clocks");
  end
  if (EARLIER_FAMILY && (REPEAT_READ_SUPPRESS_A || REPEAT_READ_SUPPRESS_B)
      && (CONTENT_INIT_VECTORS != '0 || PARITY_INIT_VECTORS != '0
          || PORT_A_INIT_VALUE != '0 || PORT_B_INIT_VALUE != '0)) begin : g_bad_init
    $error("suppression on the earlier family needs zero init");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic                    dozeReq;
    logic                    dozeMeta;
    logic                    dozeLevel;
    doze_state_t             doze;
    logic [1:0]              wakeCnt;
    logic [1:0][AW-1:0]      held;
    logic [1:0][AW-1:0]      lastRd;
    logic [1:0]              lastValid;
    logic [SKIP_W-1:0]       skipCount;
    logic                    pready;
    logic                    pslverr;
    logic [APB_DATA_W-1:0]   prdata;
  } state_t;

  typedef logic [W-1:0] mem_t [DEPTH];

  // fill the array from the init vectors, vector n at bits n*256 upward
  function automatic mem_t initialContents();
    mem_t            m;
    logic [DW-1:0]   d;
    logic [PWX-1:0]  par;
    for (int i = 0; i < DEPTH; i++) begin
      d = CONTENT_INIT_VECTORS[i*DW +: DW];
      par = PARITY_INIT_VECTORS[i*PWX +: PWX];
      m[i] = W'({par, d});                            // parity above data, dropped if none
    end
    return m;
  endfunction

  state_t                 q_r;
  state_t                 q_nxt;
  mem_t                   mem = initialContents();
  logic [1:0]             accessOn;
  logic [1:0]             writeOn;
  logic [1:0]             capture;
  logic [1:0]             regGate;
  logic [1:0]             regReset;
  logic [1:0][AW-1:0]     addrIn;
  logic [1:0][W-1:0]      wrIn;
  logic [1:0][AW-1:0]     effAddr;
  logic [1:0][W-1:0]      memOld;
  logic [1:0][W-1:0]      latchData;
  logic [1:0]             active;
  logic [1:0]             isWr;
  logic [1:0]             skip;
  logic [1:0]             load;
  logic [1:0][DATA_PINS-1:0] rdOut;
  logic                   awake;
  logic [APB_DATA_W-1:0]  statusWord;
  logic [APB_DATA_W-1:0]  ctrlWord;

  // gather the two ports into indexed form
  assign accessOn = {portBAccessOn, portAAccessOn};
  assign writeOn  = {portBWriteOn, portAWriteOn};
  assign capture  = {portBAddressCapture, portAAddressCapture};
  assign regGate  = {portBOutputRegClockGate, portAOutputRegClockGate};
  assign regReset = {portBOutputRegReset, portAOutputRegReset};
  assign addrIn   = {portBAddr[AW-1:0], portAAddr[AW-1:0]};
  assign wrIn     = {portBWrData[W-1:0], portAWrData[W-1:0]};

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    q_nxt = q_r;
    awake = (q_r.doze == DOZE_AWAKE);
    // per-port access decode
    for (int p = 0; p < 2; p++) begin
      effAddr[p] = (HOLD[p] && !capture[p]) ? q_r.held[p] : addrIn[p];
      q_nxt.held[p] = effAddr[p];
      memOld[p] = mem[effAddr[p]];
      active[p] = accessOn[p] && awake && PORT_USED[p];
      isWr[p] = active[p] && writeOn[p];
      skip[p] = SUPPRESS_ON[p] && active[p] && !writeOn[p] && q_r.lastValid[p]
                && (q_r.lastRd[p] == effAddr[p]);
      load[p] = active[p] && !skip[p] && !(isWr[p] && MODE[p] == NO_CHANGE_MODE);
      latchData[p] = (isWr[p] && MODE[p] == WRITE_FIRST_MODE) ? wrIn[p] : memOld[p];
      if (active[p] && !writeOn[p]) begin
        q_nxt.lastRd[p] = effAddr[p];
        q_nxt.lastValid[p] = 1'b1;
      end
    end
    // a write or an output reset breaks the repeat-read chain
    for (int p = 0; p < 2; p++) begin
      if ((|isWr) || regReset[p]) begin
        q_nxt.lastValid[p] = 1'b0;
      end
    end
    q_nxt.skipCount = q_r.skipCount + SKIP_W'(skip[0]) + SKIP_W'(skip[1]);
    // doze input: sampled directly or through two flops
    q_nxt.dozeMeta = q_r.dozeReq;
    q_nxt.dozeLevel = ASYNCHRONOUS_DOZE_SELECT ? q_r.dozeMeta : q_r.dozeReq;
    unique case (q_r.doze)
      DOZE_AWAKE: begin
        if (q_r.dozeLevel) begin
          q_nxt.doze = DOZE_ASLEEP;
        end
      end
      DOZE_ASLEEP: begin
        if (!q_r.dozeLevel) begin
          q_nxt.doze = DOZE_WAKING;
          q_nxt.wakeCnt = WAKE_CYCLES - 2'h1;
        end
      end
      DOZE_WAKING: begin
        if (q_r.dozeLevel) begin
          q_nxt.doze = DOZE_ASLEEP;
        end else if (q_r.wakeCnt == '0) begin
          q_nxt.doze = DOZE_AWAKE;
        end else begin
          q_nxt.wakeCnt = q_r.wakeCnt - 2'h1;
        end
      end
      default: q_nxt.doze = DOZE_AWAKE;
    endcase
    // register views
    statusWord = '0;
    statusWord[STATUS_ASLEEP_BIT] = (q_r.doze == DOZE_ASLEEP);
    statusWord[STATUS_READY_BIT] = awake;
    statusWord[STATUS_CASC_A_LSB +: $bits(cascade_t)] = CASCADE_ORDER_A;
    statusWord[STATUS_CASC_B_LSB +: $bits(cascade_t)] = CASCADE_ORDER_B;
    statusWord[STATUS_SKIP_LSB +: SKIP_W] = q_r.skipCount;
    ctrlWord = '0;
    ctrlWord[CTRL_DOZE_BIT] = q_r.dozeReq;
    // apb: answer in the first access cycle
    q_nxt.pready = 1'b0;
    q_nxt.pslverr = 1'b0;
    if (psel && !penable) begin
      q_nxt.pready = 1'b1;
      q_nxt.pslverr = (paddr != CTRL_OFFSET) && (paddr != STATUS_OFFSET);
      q_nxt.prdata = '0;
      if (!pwrite && paddr == CTRL_OFFSET) begin
        q_nxt.prdata = ctrlWord;
      end else if (!pwrite && paddr == STATUS_OFFSET) begin
        q_nxt.prdata = statusWord;
      end
    end
    if (psel && penable && q_r.pready && pwrite && paddr == CTRL_OFFSET) begin
      q_nxt.dozeReq = pwdata[CTRL_DOZE_BIT];
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // array writes; port b lands last on an address collision
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (isWr[p]) begin
        mem[effAddr[p]] <= wrIn[p];
      end
    end
  end

  // ****************************************
  // output stages
  // ****************************************
  localparam bit OUT_REG [2] = '{OUT_REG_A, OUT_REG_B};
  localparam priority_t PRIO [2] = '{PORT_A_RESET_VS_GATE_PRIORITY,
                                     PORT_B_RESET_VS_GATE_PRIORITY};
  localparam logic [DATA_PINS-1:0] RST_VAL [2] = '{PORT_A_RESET_VALUE & WMASK,
                                                   PORT_B_RESET_VALUE & WMASK};
  localparam logic [DATA_PINS-1:0] INIT_VAL [2] = '{PORT_A_INIT_VALUE & WMASK,
                                                    PORT_B_INIT_VALUE & WMASK};

  for (genvar g = 0; g < 2; g++) begin : g_out
    port_output_stage #(
      .OUT_REG     (OUT_REG[g]),
      .PRIORITY    (PRIO[g]),
      .RESET_VALUE (RST_VAL[g]),
      .INIT_VALUE  (INIT_VAL[g])
    ) u_stage (
      .clk         (clk),
      .reset_n     (reset_n),
      .loadLatch   (load[g]),
      .latchData   (DATA_PINS'(latchData[g])),
      .regGate     (regGate[g]),
      .regReset    (regReset[g]),
      .dataOut     (rdOut[g])
    );
  end

  // outputs
  assign portARdData = rdOut[0];
  assign portBRdData = rdOut[1];
  assign prdata      = q_r.prdata;
  assign pready      = q_r.pready;
  assign pslverr     = q_r.pslverr;

endmodule
`default_nettype wire

// >>> dv/dual_port_ram_sva.sv
// port assertions of the dual-port ram, bound into the design
// assumes 9-bit ports, register on port a, latch only on port b
`timescale 1ns/1ps
`default_nettype none
module dual_port_ram_sva #(
  parameter logic [8:0] RST_A = 9'h000,
  parameter logic [8:0] RST_B = 9'h000
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        portAAccessOn,
  input wire logic        portAWriteOn,
  input wire logic        portAAddressCapture,
  input wire logic [14:0] portAAddr,
  input wire logic [71:0] portAWrData,
  input wire logic        portAOutputRegClockGate,
  input wire logic        portAOutputRegReset,
  input wire logic [71:0] portARdData,
  input wire logic        portBAccessOn,
  input wire logic        portBWriteOn,
  input wire logic [14:0] portBAddr,
  input wire logic        portBOutputRegReset,
  input wire logic [71:0] portBRdData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // **************************************
  // steps of apb and port transfers
  // **************************************
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_twin_read;
    portAAccessOn && !portAWriteOn && portAAddressCapture && !portAOutputRegReset &&
      portBAccessOn && !portBWriteOn && !portBOutputRegReset && portAAddr == portBAddr;
  endsequence
  sequence s_a_write;
    portAAccessOn && portAWriteOn && !portAOutputRegReset;
  endsequence
  sequence s_pipe_move;
    portAOutputRegClockGate && !portAOutputRegReset;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
  a_unmapped_error: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04}))
    else $error("error flag wrong");
  a_reset_wins_a: assert property (portAOutputRegReset |=> portARdData[8:0] == RST_A)
    else $error("port a reset value missing");
  a_latch_reset_b: assert property (portBOutputRegReset |=> portBRdData[8:0] == RST_B)
    else $error("port b latch reset missing");
  a_pipe_extra_cycle: assert property (s_twin_read ##1 s_pipe_move |=>
    portARdData == $past(portBRdData)) else $error("pipeline latency wrong");
  a_write_first_a: assert property (s_a_write ##1 s_pipe_move |=>
    portARdData[8:0] == $past(portAWrData[8:0], 2)) else $error("write-first data wrong");
  a_gate_holds_a: assert property (!portAOutputRegClockGate && !portAOutputRegReset |=>
    $stable(portARdData)) else $error("register moved without gate");
  a_upper_bits_zero: assert property (portARdData[71:9] == '0 && portBRdData[71:9] == '0)
    else $error("bits above port width set");
endmodule
bind dual_port_ram dual_port_ram_sva #(.RST_A(9'h1a5), .RST_B(9'h0b4)) u_sva (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .portAAccessOn(portAAccessOn),
  .portAWriteOn(portAWriteOn), .portAAddressCapture(portAAddressCapture),
  .portAAddr(portAAddr), .portAWrData(portAWrData), .portARdData(portARdData),
  .portAOutputRegClockGate(portAOutputRegClockGate), .portAOutputRegReset(portAOutputRegReset),
  .portBAccessOn(portBAccessOn), .portBWriteOn(portBWriteOn), .portBAddr(portBAddr),
  .portBOutputRegReset(portBOutputRegReset), .portBRdData(portBRdData));
`default_nettype wire

// >>> dv/fabric_ports.sv
// fabric model driving both ram ports, one cycle per call of go
// assumes the bench's clock; quiet is raised by the bench around doze
`timescale 1ns/1ps
`default_nettype none
module fabric_ports (
  input  wire logic        clk,
  output var  logic        aOn,
  output var  logic        aWe,
  output var  logic        aCap,
  output var  logic [14:0] aAddr,
  output var  logic [71:0] aWd,
  output var  logic        aGate,
  output var  logic        aRst,
  output var  logic        bOn,
  output var  logic        bWe,
  output var  logic        bCap,
  output var  logic [14:0] bAddr,
  output var  logic [71:0] bWd,
  output var  logic        bGate,
  output var  logic        bRst
);
  logic quiet = 1'b0;
  // all lines low at time zero
  initial {aOn, aWe, aCap, aAddr, aWd, aGate, aRst, bOn, bWe, bCap, bAddr, bWd, bGate, bRst} = '0;
  // one cycle of traffic; c holds {b reset, a reset, gates, captures}
  task automatic go(input logic [1:0] on, input logic [1:0] we, input logic [14:0] xa,
                    input logic [14:0] xb, input logic [8:0] da, input logic [8:0] db,
                    input logic [3:0] c);
    @(posedge clk);
    aOn <= on[0] && !quiet;
    bOn <= on[1] && !quiet;
    aWe <= we[0];
    bWe <= we[1];
    aAddr <= on[0] ? xa : ~aAddr; // unused lines wander
    bAddr <= on[1] ? xb : ~bAddr;
    aWd <= we[0] ? {63'h0, da} : ~aWd;
    bWd <= we[1] ? {63'h0, db} : ~bWd;
    {bRst, aRst, aGate, aCap} <= c;
    bGate <= c[1];
    bCap <= c[0];
  endtask
endmodule
`default_nettype wire

// >>> dv/dual_port_ram_tb.sv
// self-checking bench of the dual-port ram: apb master, port traffic, doze
// assumes the fabric model for the ports and the bound checker
`timescale 1ns/1ps
`default_nettype none
module dual_port_ram_tb;
  import ram_cfg_pkg::*;
  localparam logic [CONTENT_BITS_MAX-1:0] CV = 32768'h5a << 256; // word 0x20 data
  localparam logic [PARITY_BITS_MAX-1:0]  PV = 4096'h1 << 32;    // word 0x20 parity
  typedef struct {logic [14:0] a; logic [8:0] d;} row_t;
  row_t rows [4] = '{'{15'h0010, 9'h1ff}, '{15'h0011, 9'h000}, '{15'h07ff, 9'h155},
                     '{15'h0000, 9'h0aa}};
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q, s;
  logic        pready, pslverr, e;
  logic        aOn, aWe, aCap, aGate, aRst, bOn, bWe, bCap, bGate, bRst;
  logic [14:0] aAddr, bAddr;
  logic [71:0] aWd, bWd, aRd, bRd;
  int          bad_count = 0;
  int          num_checks = 0;
  // 10 mhz clock
  initial begin
    forever #50 clk = ~clk;
  end
  dual_port_ram #(.READ_WIDTH_A(9), .READ_WIDTH_B(9), .WRITE_WIDTH_A(9), .WRITE_WIDTH_B(9),
    .WRITE_MODE_B(READ_FIRST_MODE), .OUT_REG_B(1'b0), .PORT_A_RESET_VALUE(72'h1a5),
    .PORT_B_RESET_VALUE(72'h0b4), .PORT_A_INIT_VALUE(72'h0c3), .PORT_B_INIT_VALUE(72'h03c),
    .CASCADE_ORDER_A(CASCADE_MIDDLE), .CASCADE_ORDER_B(CASCADE_LAST),
    .PORT_CLOCK_RELATION(CLOCKS_COMMON), .ADDRESS_HOLD_OPTION_A(1'b1),
    .REPEAT_READ_SUPPRESS_B(1'b1), .CONTENT_INIT_VECTORS(CV), .PARITY_INIT_VECTORS(PV)
  ) u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portAAccessOn(aOn), .portAWriteOn(aWe), .portAAddressCapture(aCap), .portAAddr(aAddr),
    .portAWrData(aWd), .portAOutputRegClockGate(aGate), .portAOutputRegReset(aRst),
    .portARdData(aRd), .portBAccessOn(bOn), .portBWriteOn(bWe), .portBAddressCapture(bCap),
    .portBAddr(bAddr), .portBWrData(bWd), .portBOutputRegClockGate(bGate),
    .portBOutputRegReset(bRst), .portBRdData(bRd));
  fabric_ports u_fab (.clk(clk), .aOn(aOn), .aWe(aWe), .aCap(aCap), .aAddr(aAddr), .aWd(aWd),
    .aGate(aGate), .aRst(aRst), .bOn(bOn), .bWe(bWe), .bCap(bCap), .bAddr(bAddr), .bWd(bWd),
    .bGate(bGate), .bRst(bRst));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk);
    while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= ~w;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // idle cycles, then sample at the falling edge
  task automatic nap(input int n);
    repeat (n) u_fab.go(2'h0, 2'h0, 15'h0, 15'h0, 9'h0, 9'h0, 4'h3);
    @(negedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog at 2000 cycles, far beyond the fewer than a hundred cycles of the run
  initial begin
    #(2000 * 100);
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    nap(1);
    chk(aRd[31:0], 32'h0c3);
    chk(bRd[31:0], 32'h03c);
    $display("test init value done");
    // table: write on a, read back on b
    foreach (rows[i]) begin
      u_fab.go(2'h1, 2'h1, rows[i].a, 15'h0, rows[i].d, 9'h0, 4'h3);
      u_fab.go(2'h2, 2'h0, 15'h0, rows[i].a, 9'h0, 9'h0, 4'h3);
      nap(1);
      chk(aRd[31:0], {23'h0, rows[i].d});
      chk(bRd[31:0], {23'h0, rows[i].d});
    end
    $display("test table done");
    apb(1'b0, STATUS_OFFSET, 32'h0, s, e);
    u_fab.go(2'h3, 2'h0, 15'h0020, 15'h0020, 9'h0, 9'h0, 4'h3);
    repeat (2) u_fab.go(2'h2, 2'h0, 15'h0, 15'h0020, 9'h0, 9'h0, 4'h3);
    nap(1);
    chk(bRd[31:0], 32'h15a);
    apb(1'b0, STATUS_OFFSET, 32'h0, q, e);
    chk({16'h0, q[31:16]}, {16'h0, s[31:16] + 16'h0002});
    u_fab.go(2'h1, 2'h0, 15'h0021, 15'h0, 9'h0, 9'h0, 4'h3);
    u_fab.go(2'h1, 2'h0, 15'h0020, 15'h0, 9'h0, 9'h0, 4'h2);
    nap(2);
    chk(aRd[31:0], 32'h0);
    u_fab.go(2'h2, 2'h2, 15'h0, 15'h0010, 9'h0, 9'h033, 4'h3);
    nap(1);
    chk(bRd[31:0], 32'h1ff);
    $display("test init content, hold and modes done");
    u_fab.go(2'h0, 2'h0, 15'h0, 15'h0, 9'h0, 9'h0, 4'hc);
    u_fab.go(2'h1, 2'h0, 15'h0010, 15'h0, 9'h0, 9'h0, 4'h0);
    nap(1);
    chk(aRd[31:0], 32'h1a5);
    chk(bRd[31:0], 32'h0b4);
    $display("test output reset done");
    u_fab.quiet = 1'b1;
    nap(1);
    apb(1'b1, CTRL_OFFSET, 32'h1, q, e);
    nap(3);
    apb(1'b0, STATUS_OFFSET, 32'h0, q, e);
    chk({26'h0, q[5:0]}, 32'h39);
    apb(1'b1, CTRL_OFFSET, 32'h0, q, e);
    apb(1'b0, STATUS_OFFSET, 32'h0, q, e);
    chk({31'h0, q[1]}, 32'h0);
    apb(1'b0, STATUS_OFFSET, 32'h0, q, e);
    chk({30'h0, q[1:0]}, 32'h2);
    u_fab.quiet = 1'b0;
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    $display("test doze and apb done");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    nap(1);
    chk(aRd[31:0], 32'h0c3);
    chk(bRd[31:0], 32'h03c);
    $display("test second reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
